// ### dv/mtc_crc_gen_monitor.sv
// Port checker for the check-code generator.
// Assumes one clock domain and the asynchronous active-low reset of the block.
`timescale 1ns/100ps
module mtc_crc_gen_monitor #(
    parameter [7:0] ROM_CHECK = 8'h5e
) (
    input wire        sys_clk_i,
    input wire        rst_n_i,
    input wire        cmd_start_i,
    input wire        out_valid_o,
    input wire [7:0]  out_byte_o,
    input wire        out_ready_i,
    input wire [15:0] crc_o,
    input wire        mem_wr_o,
    input wire [15:0] mem_addr_o,
    input wire        byte_ready_o,
    input wire [7:0]  rom_check_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rom; rom_check_o == ROM_CHECK; endproperty
    a_rom: assert property (p_rom) else $error("rom check byte changed");
    property p_clear; cmd_start_i |=> crc_o == 16'h0000; endproperty
    a_clear: assert property (p_clear) else $error("generator not cleared");
    property p_wr_pulse; mem_wr_o |=> !mem_wr_o; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("commit longer than one cycle");
    property p_wr_drained; mem_wr_o |-> !out_valid_o && !$past(out_valid_o); endproperty
    a_wr_drained: assert property (p_wr_drained) else $error("commit before code sent");
    property p_wr_load; mem_wr_o |-> crc_o == mem_addr_o + 16'h0001; endproperty
    a_wr_load: assert property (p_wr_load) else $error("next address not loaded");
    property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_byte_o); endproperty
    a_hold: assert property (p_hold) else $error("code byte dropped while stalled");
    property p_code_due; $fell(byte_ready_o) |-> ##[1:4] out_valid_o; endproperty
    a_code_due: assert property (p_code_due) else $error("code not offered");
    property p_wr_ready; mem_wr_o |-> byte_ready_o; endproperty
    a_wr_ready: assert property (p_wr_ready) else $error("not ready after commit");
    c_commit: cover property (mem_wr_o);
    c_stall: cover property (out_valid_o && !out_ready_i);
    c_start: cover property (cmd_start_i);
endmodule // mtc_crc_gen_monitor
bind mtc_crc_gen mtc_crc_gen_monitor #(.ROM_CHECK(ROM_CHECK)) u_mon (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .cmd_start_i(cmd_start_i), .out_valid_o(out_valid_o),
    .out_byte_o(out_byte_o), .out_ready_i(out_ready_i), .crc_o(crc_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .byte_ready_o(byte_ready_o), .rom_check_o(rom_check_o));

// ### dv/mtc_link_model.sv
// Far-end link master: takes code bytes, prompt or stalling every other cycle.
// Assumes the block's clock; the last two bytes are kept low byte first.
`timescale 1ns/100ps
module mtc_link_model (
    input  wire       sys_clk_i,
    input  wire       rst_n_i,
    input  wire       slow_i,
    input  wire       out_valid_i,
    input  wire [7:0] out_byte_i,
    output reg        out_ready_o,
    output reg [15:0] code_o,
    output reg [7:0]  cnt_o
);
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ready_o <= 1'b0;
            code_o      <= 16'h0000;
            cnt_o       <= 8'h00;
        end else begin
            out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
            if (out_valid_i && out_ready_o) begin
                code_o <= {out_byte_i, code_o[15:8]};
                cnt_o  <= cnt_o + 8'h01;
            end
        end
    end
endmodule // mtc_link_model

// ### dv/test_mtc_crc_gen.sv
// Self-checking bench for the check-code generator with a link model on the code side.
// Assumes the design header is on the include path.
`timescale 1ns/100ps
`include "mtc_defs.vh"
module test_mtc_crc_gen;
    reg sys_clk_i = 1'b0, rst_n_i = 1'b0, cmd_start_i = 1'b0, byte_valid_i = 1'b0, slow = 1'b0;
    reg  [7:0] byte_i = 8'h00;
    wire out_valid_o, out_ready_i, mem_wr_o, byte_ready_o, busy_o;
    wire [7:0] out_byte_o, mem_data_o, rom_check_o, cnt;
    wire [15:0] crc_o, mem_addr_o, code;
    integer num_errors = 0, n_tests = 0, cyc = 0, i;
    reg [15:0] e;
    always #20 sys_clk_i = ~sys_clk_i;
    mtc_crc_gen dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_start_i(cmd_start_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
        .out_valid_o(out_valid_o), .out_byte_o(out_byte_o), .out_ready_i(out_ready_i),
        .crc_o(crc_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
        .rom_check_o(rom_check_o), .busy_o(busy_o));
    mtc_link_model u_link (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .out_valid_i(out_valid_o), .out_byte_i(out_byte_o), .out_ready_o(out_ready_i),
        .code_o(code), .cnt_o(cnt));
    // Reference generator, shifted least significant bit first.
    function [15:0] f(input [15:0] c, input [7:0] d);
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
                c = (c[0] ^ d[k]) ? ((c >> 1) ^ `MTC_POLY16_REFL) : (c >> 1);
            f = c;
        end
    endfunction
    // Far-end 8-bit identification code over the 56 body bits, LSB first.
    function [7:0] f8(input [55:0] v);
        integer k;
        begin
            f8 = 8'h00;
            for (k = 0; k < 56; k = k + 1)
                f8 = (f8[0] ^ v[k]) ? ((f8 >> 1) ^ `MTC_POLY8_REFL) : (f8 >> 1);
        end
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("errors=%0d checks=%0d", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    always @(posedge sys_clk_i) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    task go;
        begin
            @(posedge sys_clk_i) cmd_start_i <= 1'b1;
            @(posedge sys_clk_i) cmd_start_i <= 1'b0;
        end
    endtask
    task put(input [7:0] b);
        begin
            // One idle edge between bytes so valid is never lowered and raised at once.
            @(posedge sys_clk_i);
            byte_valid_i <= 1'b1;
            byte_i <= b;
            do @(posedge sys_clk_i); while (byte_ready_o !== 1'b1);
            byte_valid_i <= 1'b0;
        end
    endtask
    // Waits for two code bytes and compares them with the complemented reference.
    task code_is(input [15:0] exp);
        reg [7:0] c0;
        begin
            c0 = cnt;
            for (i = 0; i < 100 && cnt !== c0 + 8'h02; i = i + 1) @(posedge sys_clk_i);
            chk(code, ~exp);
        end
    endtask
    task t_reset;
        begin
            chk({8'h00, rom_check_o}, {8'h00, `MTC_ROM_CHECK});
            chk({8'h00, rom_check_o}, {8'h00, f8(`MTC_ROM_BODY)});
            chk({14'h0000, out_valid_o, mem_wr_o}, 16'h0000);
            chk(crc_o, 16'h0000);
        end
    endtask
    task t_read;
        begin
            slow <= 1'b1;
            go;
            put(`MTC_CMD_READ_MEM);
            put(8'h07);
            put(8'h00);
            put(8'hd0);
            code_is(f(f(f(f(16'h0000, 8'haa), 8'h07), 8'h00), 8'hd0));
            e = 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                put(8'h30 + i);
                e = f(e, 8'h30 + i);
            end
            code_is(e);
        end
    endtask
    task wr_commit(input [15:0] a, input [7:0] d);
        begin
            for (i = 0; i < 100 && mem_wr_o !== 1'b1; i = i + 1) @(posedge sys_clk_i);
            chk(mem_addr_o, a);
            chk({8'h00, mem_data_o}, {8'h00, d});
            chk({15'h0000, busy_o}, 16'h0000);
            chk({15'h0000, byte_ready_o}, 16'h0001);
        end
    endtask
    task t_write;
        begin
            slow <= 1'b0;
            go;
            put(`MTC_CMD_WRITE_MEM);
            put(8'h16);
            put(8'h00);
            put(8'h64);
            code_is(f(f(f(f(16'h0000, 8'h55), 8'h16), 8'h00), 8'h64));
            chk({15'h0000, busy_o}, 16'h0001);
            wr_commit(16'h0016, 8'h64);
            put(8'h96);
            code_is(f(16'h0017, 8'h96));
            wr_commit(16'h0017, 8'h96);
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        t_reset;
        rst_n_i <= 1'b1;
        t_read;
        t_write;
        end_sim;
    end
endmodule // test_mtc_crc_gen

// ### hw/mtc_crc_gen.v
// Check-code generator for memory read and write transactions of a serial-bus converter.
// Assumes the slot logic on the same clock delivers each byte of the transaction, in link
// order, on the byte stream, and pulses cmd_start_i once the memory command phase begins.
`timescale 1ns/100ps
`include "mtc_defs.vh"
module mtc_crc_gen #(
    parameter [7:0] ROM_CHECK  = `MTC_ROM_CHECK,
    parameter       FIFO_DEPTH = `MTC_FIFO_DEPTH,
    parameter       FIFO_AW    = `MTC_FIFO_AW
) (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        cmd_start_i,
    input  wire        byte_valid_i,
    input  wire [7:0]  byte_i,
    output reg         byte_ready_o,
    output wire        out_valid_o,
    output wire [7:0]  out_byte_o,
    input  wire        out_ready_i,
    output reg  [15:0] crc_o,
    output reg         mem_wr_o,
    output reg  [15:0] mem_addr_o,
    output reg  [7:0]  mem_data_o,
    output reg  [7:0]  rom_check_o,
    output reg         busy_o
);
    // One-hot state codes.
    localparam [7:0] S_CMD    = 8'h01;
    localparam [7:0] S_ADDR_L = 8'h02;
    localparam [7:0] S_ADDR_H = 8'h04;
    localparam [7:0] S_DATA   = 8'h08;
    localparam [7:0] S_CRC_LO = 8'h10;
    localparam [7:0] S_CRC_HI = 8'h20;
    localparam [7:0] S_COMMIT = 8'h40;
    localparam [7:0] S_IGNORE = 8'h80;

    reg  [7:0]  state;
    reg  [7:0]  next_state;
    reg  [15:0] crc;
    reg  [15:0] next_crc;
    reg  [15:0] addr;
    reg  [15:0] next_addr;
    reg  [15:0] tx_code;
    reg  [15:0] next_tx_code;
    reg  [7:0]  wr_data;
    reg  [7:0]  next_wr_data;
    reg         is_write;
    reg         next_is_write;
    reg         next_mem_wr;
    reg         push;
    reg  [7:0]  push_byte;

    wire        fifo_ready;
    wire        fifo_idle;
    wire        take = byte_valid_i && byte_ready_o;

    // Parallel equivalent of eight serial steps, least significant bit first.
    // Only the incoming byte is ever shifted, so a single chain serves every state.
    wire [15:0] crc_step [0:8];
    wire [15:0] crc_shift = crc_step[8];
    genvar      b;

    assign crc_step[0] = crc;

    generate
        for (b = 0; b < 8; b = b + 1) begin : g_crc_bit
            assign crc_step[b+1] = (crc_step[b][0] ^ byte_i[b]) ?
                                   ({1'b0, crc_step[b][15:1]} ^ `MTC_POLY16_REFL) :
                                   {1'b0, crc_step[b][15:1]};
        end
    endgenerate

    always @* begin
        next_state    = state;
        next_crc      = crc;
        next_addr     = addr;
        next_tx_code  = tx_code;
        next_wr_data  = wr_data;
        next_is_write = is_write;
        next_mem_wr   = 1'b0;
        push          = 1'b0;
        push_byte     = 8'h00;
        if (cmd_start_i) begin
            next_state = S_CMD;
            next_crc   = `MTC_CRC16_CLEAR;
        end else begin
            case (state)
                S_CMD: begin
                    if (take) begin
                        next_crc = crc_shift;
                        if (byte_i == `MTC_CMD_READ_MEM) begin
                            next_is_write = 1'b0;
                            next_state    = S_ADDR_L;
                        end else if (byte_i == `MTC_CMD_WRITE_MEM) begin
                            next_is_write = 1'b1;
                            next_state    = S_ADDR_L;
                        end else begin
                            next_state = S_IGNORE;
                        end
                    end
                end
                S_ADDR_L: begin
                    if (take) begin
                        next_crc        = crc_shift;
                        next_addr[7:0]  = byte_i;
                        next_state      = S_ADDR_H;
                    end
                end
                S_ADDR_H: begin
                    if (take) begin
                        next_crc        = crc_shift;
                        next_addr[15:8] = byte_i;
                        next_state      = S_DATA;
                    end
                end
                S_DATA: begin
                    if (take) begin
                        next_crc = crc_shift;
                        if (is_write) begin
                            next_wr_data = byte_i;
                            next_tx_code = ~next_crc;
                            next_state   = S_CRC_LO;
                        end else begin
                            next_addr = addr + 16'h0001;
                            if (addr[2:0] == `MTC_PAGE_LAST) begin
                                next_tx_code = ~next_crc;
                                next_state   = S_CRC_LO;
                            end
                        end
                    end
                end
                S_CRC_LO: begin
                    push      = 1'b1;
                    push_byte = tx_code[7:0];
                    if (fifo_ready) begin
                        next_state = S_CRC_HI;
                    end
                end
                S_CRC_HI: begin
                    push      = 1'b1;
                    push_byte = tx_code[15:8];
                    if (fifo_ready) begin
                        if (is_write) begin
                            next_state = S_COMMIT;
                        end else begin
                            next_crc   = `MTC_CRC16_CLEAR;
                            next_state = S_DATA;
                        end
                    end
                end
                S_COMMIT: begin
                    // The byte is stored only once the code has left on the link.
                    if (fifo_idle) begin
                        next_mem_wr = 1'b1;
                        next_addr   = addr + 16'h0001;
                        next_crc    = addr + 16'h0001;
                        next_state  = S_DATA;
                    end
                end
                S_IGNORE: begin
                    next_state = S_IGNORE;
                end
                default: begin
                    next_state = S_IGNORE;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state        <= S_IGNORE;
            crc          <= `MTC_CRC16_CLEAR;
            addr         <= 16'h0000;
            tx_code      <= 16'h0000;
            wr_data      <= 8'h00;
            is_write     <= 1'b0;
            byte_ready_o <= 1'b0;
            crc_o        <= `MTC_CRC16_CLEAR;
            mem_wr_o     <= 1'b0;
            mem_addr_o   <= 16'h0000;
            mem_data_o   <= 8'h00;
            rom_check_o  <= ROM_CHECK;
            busy_o       <= 1'b0;
        end else begin
            state        <= next_state;
            crc          <= next_crc;
            addr         <= next_addr;
            tx_code      <= next_tx_code;
            wr_data      <= next_wr_data;
            is_write     <= next_is_write;
            // Bytes are refused while the code is queued or the write waits to commit.
            byte_ready_o <= (next_state == S_CMD) || (next_state == S_ADDR_L) ||
                            (next_state == S_ADDR_H) || (next_state == S_DATA) ||
                            (next_state == S_IGNORE);
            crc_o        <= next_crc;
            mem_wr_o     <= next_mem_wr;
            mem_addr_o   <= addr;
            mem_data_o   <= wr_data;
            // The factory byte is a constant; nothing here ever recomputes it.
            rom_check_o  <= ROM_CHECK;
            busy_o       <= (next_state == S_CRC_LO) || (next_state == S_CRC_HI) ||
                            (next_state == S_COMMIT);
        end
    end

    mtc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_data_i   (push_byte),
        .in_ready_o  (fifo_ready),
        .out_valid_o (out_valid_o),
        .out_data_o  (out_byte_o),
        .out_ready_i (out_ready_i),
        .idle_o      (fifo_idle)
    );
endmodule // mtc_crc_gen

// ### hw/mtc_defs.vh
// Constants shared by the memory-transfer check-code generator and its output FIFO.
// Assumes inclusion by bare name from files under hw/.
`ifndef MTC_DEFS_VH
`define MTC_DEFS_VH

// Memory function command codes seen as the first byte after the ROM phase.
`define MTC_CMD_READ_MEM   8'haa
`define MTC_CMD_WRITE_MEM  8'h55

// Reflected 16-bit memory-transfer polynomial, powers 16, 15, 2 and 0, shifted LSB first.
`define MTC_POLY16_REFL    16'ha001
// Reflected 8-bit identification polynomial, powers 8, 5, 4 and 0, used by the far end.
`define MTC_POLY8_REFL     8'h8c
// Value the generator is cleared to at command start and after each read page; a write commit loads the next address instead.
`define MTC_CRC16_CLEAR    16'h0000

// Memory page geometry: 8 bytes per page, low three address bits select the byte.
`define MTC_PAGE_LAST      3'h7

// Identification body, 56 bits sent LSB first; the value here is arbitrary.
`define MTC_ROM_BODY       56'h01000000000000
// Factory check byte: the 8-bit code of the body above, stored once and never recomputed.
`define MTC_ROM_CHECK      8'h5e

// Output FIFO geometry.
`define MTC_FIFO_DEPTH     16
`define MTC_FIFO_AW        4

`endif

// ### hw/mtc_fifo.v
// Byte FIFO with valid/ready on both sides and a registered read port.
// Assumes a single clock and a drain side that may stall at any time.
`timescale 1ns/100ps
module mtc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             in_ready_o,
    output reg              out_valid_o,
    output reg  [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i,
    output wire             idle_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;

    wire full  = (count == DEPTH[AW:0]);
    wire empty = (count == {(AW+1){1'b0}});
    wire push  = in_valid_i && !full;
    // The output register is refilled whenever it is empty or being taken.
    wire pop   = !empty && (!out_valid_o || out_ready_i);

    assign in_ready_o = !full;
    assign idle_o     = empty && !out_valid_o;

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= {AW{1'b0}};
            rd_ptr      <= {AW{1'b0}};
            count       <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr     <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
            if (pop) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule // mtc_fifo
